/* File: hdl/cssf_pkg.sv */
/*
  Package for the clock source select and oscillator fault block: source
  encodings, field widths, reset values and filter timing.
  Assumes one 50 MHz system clock and no register bus.
*/
package cssf_pkg;
  // clock source encodings held in each select field
  localparam int SEL_W = 3;
  localparam logic [2:0] SRC_CRYS1 = 3'h0;
  localparam logic [2:0] SRC_VLO = 3'h1;
  localparam logic [2:0] SRC_REFO = 3'h2;
  localparam logic [2:0] SRC_DIGOSC = 3'h3;
  localparam logic [2:0] SRC_DIGOSC_DIV = 3'h4;
  localparam logic [2:0] SRC_CRYS2 = 3'h5;
  // reset values of the select fields
  localparam logic [2:0] MAIN_SEL_RST = 3'h4;
  localparam logic [2:0] SUB_SEL_RST = 3'h4;
  localparam logic [2:0] AUX_SEL_RST = 3'h0;
  // fault flag positions in the fault flag vector
  localparam int FLT_W = 2;
  localparam int FLT_CRYS1 = 0;
  localparam int FLT_CRYS2 = 1;
  localparam logic [1:0] FLT_RST = 2'h0;
  // crystal fault filter time, in ns, and its cycle count at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAULT_FILT_NS = 200;
  localparam int FAULT_FILT_CYC = FAULT_FILT_NS / CLK_PERIOD_NS;
endpackage

/* File: hdl/cssf_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one pin level.
  Assumes the input is asynchronous to clock; the output changes only
  when the second and third stages agree.
*/
`timescale 1ns/100ps
module cssf_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // level in and filtered level out
  input wire logic async_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic agree;

  // second and third stage agreement; the first stage feeds only s2
  assign agree = (s2_q == s3_q);
  assign level_out = lvl_q;

  // shift chain and filtered level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end
endmodule

/* File: hdl/cssf_top.sv */
/*
  Clock source select and crystal oscillator fault flag logic.
  Select fields route oscillator sources to main, sub-system and
  auxiliary clocks; crystal fault flags feed a combined fault flag that
  may raise a non-maskable interrupt. Assumes software drives the plain
  control ports in the system clock domain; crystal status pins are
  asynchronous.
*/
// What this block and the software driving it do
// R01 - select write switches clocks to new source
// R02 - select write may spuriously set crystal faults
// R03 - enabled combined fault raises non-maskable interrupt
// R04 - any select field change can trigger it
// R05 - software clears all faults after select change
// R06 - software disables fault interrupt while switching; the bench keeps it enabled for the per-field switches
// R07 - handler clears false flags to release combined
// R08 - tuning routine repeats loop while frequency high
// R09 - software waits 32x32 reference periods settling
`timescale 1ns/100ps
module cssf_top #(
  parameter int SEL_W = cssf_pkg::SEL_W,
  parameter int FILT_CYC = cssf_pkg::FAULT_FILT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // clock select register write
  input wire logic sel_wr,
  input wire logic [SEL_W-1:0] main_clock_source_select,
  input wire logic [SEL_W-1:0] subsystem_clock_source_select,
  input wire logic [SEL_W-1:0] auxiliary_clock_source_select,
  // crystal configuration and status pins
  input wire logic first_crystal_enable,
  input wire logic second_crystal_enable,
  input wire logic first_crystal_ok,
  input wire logic second_crystal_ok,
  // fault flag register access
  input wire logic [1:0] fault_clear,
  input wire logic fault_nmi_enable,
  // frequency locked loop control
  input wire logic frequency_locked_loop_enable,
  // clock routing outputs
  output logic [SEL_W-1:0] main_src,
  output logic [SEL_W-1:0] sub_src,
  output logic [SEL_W-1:0] aux_src,
  // fault flags, interrupt and loop status
  output logic [1:0] fault_flags,
  output logic combined_oscillator_fault_flag,
  output logic nmi_req,
  output logic loop_active
);
  logic [SEL_W-1:0] main_q;
  logic [SEL_W-1:0] sub_q;
  logic [SEL_W-1:0] aux_q;
  logic [1:0] flt_q;
  logic [1:0] flt_d;
  logic ofi_q;
  logic nmi_q;
  logic loop_q;
  logic crys1_ok_s;
  logic crys2_ok_s;
  logic [1:0] bad;
  logic [1:0] bad_filt;
  logic [1:0] spur;
  logic [1:0] set_ev;
  logic sel_change;
  logic [7:0] filt_cnt_q [2];

  // crystal status pins pass the three-stage filter
  cssf_sync u_crys1 (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(first_crystal_ok),
    .level_out(crys1_ok_s)
  );
  cssf_sync u_crys2 (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(second_crystal_ok),
    .level_out(crys2_ok_s)
  );

  // a crystal is bad when absent or not configured
  assign bad[cssf_pkg::FLT_CRYS1] = !(first_crystal_enable && crys1_ok_s);
  assign bad[cssf_pkg::FLT_CRYS2] = !(second_crystal_enable && crys2_ok_s);

  // any change of any field counts, whatever the combination; see R04
  assign sel_change = sel_wr && ((main_clock_source_select != main_q) ||
                      (subsystem_clock_source_select != sub_q) ||
                      (auxiliary_clock_source_select != aux_q));

  // erroneous clock request hits absent crystals on a switch; see R02
  assign spur = sel_change ? bad : 2'h0;

  // genuine faults only after bad persists for the filter time
  genvar g;
  generate
    for (g = 0; g < cssf_pkg::FLT_W; g++) begin : g_filt
      assign bad_filt[g] = (filt_cnt_q[g] == 8'(FILT_CYC));
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          filt_cnt_q[g] <= 8'h00;
        end else if (!bad[g]) begin
          filt_cnt_q[g] <= 8'h00;
        end else if (!bad_filt[g]) begin
          filt_cnt_q[g] <= filt_cnt_q[g] + 8'h01;
        end
      end
    end
  endgenerate

  // set wins over a software clear in the same cycle
  assign set_ev = spur | bad_filt;
  assign flt_d = (flt_q & ~fault_clear) | set_ev;

  // select fields take the written sources; see R01
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_q <= SEL_W'(cssf_pkg::MAIN_SEL_RST);
      sub_q <= SEL_W'(cssf_pkg::SUB_SEL_RST);
      aux_q <= SEL_W'(cssf_pkg::AUX_SEL_RST);
    end else if (sel_wr) begin
      main_q <= main_clock_source_select;
      sub_q <= subsystem_clock_source_select;
      aux_q <= auxiliary_clock_source_select;
    end
  end

  // fault flags, combined flag and interrupt; see R03
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flt_q <= cssf_pkg::FLT_RST;
      ofi_q <= 1'b0;
      nmi_q <= 1'b0;
      loop_q <= 1'b0;
    end else begin
      flt_q <= flt_d;
      ofi_q <= |flt_d;
      nmi_q <= (|flt_d) && fault_nmi_enable;
      loop_q <= frequency_locked_loop_enable;
    end
  end

  assign main_src = main_q;
  assign sub_src = sub_q;
  assign aux_src = aux_q;
  assign fault_flags = flt_q;
  assign combined_oscillator_fault_flag = ofi_q;
  assign nmi_req = nmi_q;
  assign loop_active = loop_q;

  // assertions; a write is only seen as a switch when a field differs
  sequence s_switch_bad;
    sel_change && (|bad);
  endsequence
  sequence s_aux_switch_bad;
    sel_wr && (auxiliary_clock_source_select != aux_q) && bad[1];
  endsequence
  sequence s_clear_during_set;
    sel_change && bad[1] && fault_clear[1];
  endsequence

  chk_select_takes: assert property (@(posedge clock) disable iff (!rst_n)
    sel_wr |=> main_src == $past(main_clock_source_select) &&
      aux_src == $past(auxiliary_clock_source_select)) // see R01
    else $error("select field not taken");
  chk_spur_sets: assert property (@(posedge clock) disable iff (!rst_n)
    s_switch_bad |=> (fault_flags & $past(bad)) == $past(bad)) // see R02
    else $error("spurious fault not set");
  chk_nmi_raise: assert property (@(posedge clock) disable iff (!rst_n)
    (s_switch_bad ##0 fault_nmi_enable) |=> nmi_req) // see R03
    else $error("nmi not raised");
  chk_nmi_gate: assert property (@(posedge clock) disable iff (!rst_n)
    nmi_req |-> combined_oscillator_fault_flag) // see R03
    else $error("nmi without combined flag");
  chk_any_change: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_wr && subsystem_clock_source_select != sub_q && bad[0])
    |=> fault_flags[0]) // see R04
    else $error("sub change did not flag");
  chk_clear_works: assert property (@(posedge clock) disable iff (!rst_n)
    (fault_clear == 2'h3 && set_ev == 2'h0) |=>
      !combined_oscillator_fault_flag) // see R03
    else $error("clear did not release combined flag");
  chk_no_switch: assert property (@(posedge clock) disable iff (!rst_n)
    (!sel_wr && bad_filt == 2'h0 && fault_flags == 2'h0) |=>
      fault_flags == 2'h0) // see R02
    else $error("flag set without cause");
  chk_sub_takes: assert property (@(posedge clock) disable iff (!rst_n)
    sel_wr |=> sub_src == $past(subsystem_clock_source_select)) // see R01
    else $error("sub select not taken");
  chk_same_write: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_wr && !sel_change) |=>
      $stable(main_src) && $stable(sub_src) && $stable(aux_src)) // see R01
    else $error("identical write moved a source");
  chk_aux_change: assert property (@(posedge clock) disable iff (!rst_n)
    s_aux_switch_bad |=> fault_flags[1]) // see R04
    else $error("aux change did not flag");
  chk_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
    s_clear_during_set |=> fault_flags[1]) // see R02
    else $error("clear beat a spurious set");
  chk_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (fault_flags[0] && !fault_clear[0]) |=> fault_flags[0]) // see R02
    else $error("fault flag dropped without clear");
  chk_comb_or: assert property (@(posedge clock) disable iff (!rst_n)
    combined_oscillator_fault_flag == (|fault_flags)) // see R03
    else $error("combined flag differs from flags");
  chk_nmi_mask: assert property (@(posedge clock) disable iff (!rst_n)
    !fault_nmi_enable |=> !nmi_req) // see R03
    else $error("nmi raised while disabled");
endmodule

/* File: sim/cssf_top_bench.sv */
/*
  Self-checking bench for the clock source select and fault flag block.
  Assumes the crystal status pins settle within a dozen cycles after reset.
*/
`timescale 1ns/100ps
module cssf_top_bench;
  logic clock = 0, rst_n = 0, sel_wr = 0, fnmi = 0, loop_en = 0;
  logic [2:0] msel = 3'h0, ssel = 3'h0, asel = 3'h0, m, s, a;
  logic x1_en = 1, x2_en = 1, x1_ok = 1, x2_ok = 1;
  logic [1:0] fclr = 2'h0, bad;
  logic [2:0] msrc, ssrc, asrc;
  logic [1:0] flags;
  logic comb, nmi, loop_act;
  int n_errors = 0, n_tests = 0;

  // long filter so a briefly unconfigured crystal never matures to a fault
  cssf_top #(.FILT_CYC(255)) uut (
    .clock(clock), .rst_n(rst_n), .sel_wr(sel_wr),
    .main_clock_source_select(msel), .subsystem_clock_source_select(ssel),
    .auxiliary_clock_source_select(asel),
    .first_crystal_enable(x1_en), .second_crystal_enable(x2_en),
    .first_crystal_ok(x1_ok), .second_crystal_ok(x2_ok),
    .fault_clear(fclr), .fault_nmi_enable(fnmi),
    .frequency_locked_loop_enable(loop_en),
    .main_src(msrc), .sub_src(ssrc), .aux_src(asrc), .fault_flags(flags),
    .combined_oscillator_fault_flag(comb), .nmi_req(nmi),
    .loop_active(loop_act));

  always #10 clock = ~clock;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one select write, optionally with a clear in the same cycle
  task wr(input logic [2:0] wm, ws, wa, input logic [1:0] clr);
    @(posedge clock);
    sel_wr <= 1'b1; msel <= wm; ssel <= ws; asel <= wa; fclr <= clr;
    @(posedge clock);
    sel_wr <= 1'b0; fclr <= 2'h0;
    #1;
  endtask

  // software clears every fault and reconfigures both crystals
  task clear_all;
    @(posedge clock);
    x1_en <= 1'b1; x2_en <= 1'b1; fclr <= 2'h3;
    @(posedge clock);
    fclr <= 2'h0;
    repeat (2) @(posedge clock);
    #1;
    check(8'(flags), 8'h00);
    check(8'(comb), 8'h00);
  endtask

  task test_done;
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    test_done;
  end

  initial begin
    @(posedge clock);
    #1;
    check({msrc, ssrc, 2'h0},
      {cssf_pkg::MAIN_SEL_RST, cssf_pkg::SUB_SEL_RST, 2'h0});
    check({asrc, flags, comb, nmi, loop_act},
      {cssf_pkg::AUX_SEL_RST, 5'h00});
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
    // good crystals: a switch changes sources and sets nothing
    m = cssf_pkg::SRC_DIGOSC; s = cssf_pkg::SRC_REFO; a = cssf_pkg::SRC_VLO;
    wr(m, s, a, 2'h0);
    check({msrc, ssrc, 2'h0}, {m, s, 2'h0});
    check({asrc, flags, 3'h0}, {a, 5'h00});
    @(posedge clock);
    fnmi <= 1'b1;
    // each field alone, with crystal 1, then crystal 2, then both crystals left unconfigured
    for (int i = 0; i < 3; i++) begin
      bad = 2'(i + 1);
      @(posedge clock);
      x1_en <= !bad[0]; x2_en <= !bad[1];
      if (i == 0) m = cssf_pkg::SRC_CRYS1;
      if (i == 1) s = cssf_pkg::SRC_CRYS2;
      if (i == 2) a = cssf_pkg::SRC_DIGOSC_DIV;
      wr(m, s, a, 2'h0);
      check({msrc, ssrc, asrc}, {m, s, a});
      check(8'(flags), 8'(bad));
      check({comb, nmi}, 8'h03);
      clear_all;
    end
    // identical rewrite with a crystal unconfigured leaves flags clear
    @(posedge clock);
    x1_en <= 1'b0;
    wr(m, s, a, 2'h0);
    check(8'(flags), 8'h00);
    // a clear in the same cycle as a spurious set loses
    m = cssf_pkg::SRC_REFO;
    wr(m, s, a, 2'h1);
    check(8'(flags), 8'h01);
    clear_all;
    // with the interrupt disabled the combined flag still rises
    @(posedge clock);
    fnmi <= 1'b0;
    x2_en <= 1'b0;
    m = cssf_pkg::SRC_VLO;
    wr(m, s, a, 2'h0);
    check({comb, nmi}, 8'h02);
    clear_all;
    // loop enable is mirrored for the tuning routine
    @(posedge clock);
    loop_en <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(8'(loop_act), 8'h01);
    // hold the loop for the worst-case settling time before turning it off
    repeat (32 * 32) @(posedge clock);
    loop_en <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(8'(loop_act), 8'h00);
    test_done;
  end
endmodule
